// ### hw/ism_defs.vh
// Purpose: constants of the instrument status monitor
// Assumes: 32-bit register bus, byte addresses
// Notes: one macro per figure
`ifndef ISM_DEFS_VH
`define ISM_DEFS_VH

// Register byte offsets
`define ISM_OFF_IN1_HIGH 8'h00
`define ISM_OFF_IN1_LOW 8'h04
`define ISM_OFF_IN2_HIGH 8'h08
`define ISM_OFF_IN2_LOW 8'h0c
`define ISM_OFF_TIME_LO 8'h10
`define ISM_OFF_TIME_HI 8'h14
`define ISM_OFF_FLAGS 8'h18
`define ISM_OFF_TCP_LOSS 8'h1c
`define ISM_OFF_UDP_LOSS 8'h20
`define ISM_OFF_FIFO_FILL 8'h24
`define ISM_OFF_OVER_TEMP 8'h28
`define ISM_OFF_IRQ_STATUS 8'h2c
`define ISM_OFF_IRQ_MASK 8'h30

// Health flag word layout
`define ISM_FLG_IN_OVF 0
`define ISM_FLG_APLL_FAIL 2
`define ISM_FLG_DAC_OK 3
`define ISM_FLG_OUT_CLIP 5
`define ISM_FLG_EXT_REF 7
`define ISM_FLG_SAMPLE_LOSS 11
`define ISM_FLG_TRIG 12
`define ISM_FLG_PLL_LOCK 20
`define ISM_FLG_ATOMIC_LOCK 24
`define ISM_FLG_MATH_OVF 25
`define ISM_FLG_WIDTH 29

// Interrupt status layout
`define ISM_IRQ_OVER_TEMP 0
`define ISM_IRQ_TCP_LOSS 1
`define ISM_IRQ_UDP_LOSS 2
`define ISM_IRQ_FIFO_FULL 3
`define ISM_IRQ_WIDTH 4

// Reset values
`define ISM_RST_IRQ_MASK 4'h0

// Timing and limits
`define ISM_CLK_KHZ 25000
`define ISM_WINDOW_MS 100
`define ISM_TEMP_LIMIT_C 85
`define ISM_PERCENT_FULL 100

// AXI responses
`define ISM_RESP_OKAY 2'b00
`define ISM_RESP_SLVERR 2'b10

`endif

// ### hw/ism_peak.v
// Purpose: windowed largest and smallest sample of one input
// Assumes: samples and window strobe on mclk
// Notes: a window with no sample keeps the previous result
module ism_peak #(
  parameter SW = 16
) (
  input wire mclk,
  input wire rst,
  input wire win_end,
  input wire smp_valid,
  input wire [SW-1:0] smp,
  output reg [SW-1:0] peak_high,
  output reg [SW-1:0] peak_low
);

reg [SW-1:0] run_high;
reg [SW-1:0] run_low;
reg seen;
reg [SW-1:0] next_high;
reg [SW-1:0] next_low;

// Fold the current sample in before publishing
always @* begin
  next_high = run_high;
  next_low = run_low;
  if (smp_valid) begin
    if (!seen || $signed(smp) > $signed(run_high))
      next_high = smp;
    if (!seen || $signed(smp) < $signed(run_low))
      next_low = smp;
  end
end

always @(posedge mclk) begin
  if (rst) begin
    run_high <= {SW{1'b0}};
    run_low <= {SW{1'b0}};
    seen <= 1'b0;
    peak_high <= {SW{1'b0}};
    peak_low <= {SW{1'b0}};
  end else if (win_end) begin
    if (seen || smp_valid) begin
      peak_high <= next_high;
      peak_low <= next_low;
    end
    seen <= 1'b0;
  end else begin
    run_high <= next_high;
    run_low <= next_low;
    seen <= seen | smp_valid;
  end
end

endmodule

// ### hw/ism_axil.v
// Purpose: AXI4-Lite slave front end
// Assumes: one outstanding write and one outstanding read
// Notes: read data is sampled from the decoder at the address beat
`include "ism_defs.vh"

module ism_axil (
  input wire mclk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire wr_en,
  output reg [7:0] wr_addr,
  output reg [31:0] wr_data,
  output reg [3:0] wr_strb,
  input wire wr_err,
  output wire rd_en,
  output wire [7:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_err
);

reg aw_held;
reg w_held;

assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;
assign wr_en = aw_held && w_held && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
assign rd_en = s_axi_arvalid && !s_axi_rvalid;
assign rd_addr = s_axi_araddr;

always @(posedge mclk) begin
  if (rst) begin
    aw_held <= 1'b0;
    w_held <= 1'b0;
    wr_addr <= 8'h00;
    wr_data <= 32'h00000000;
    wr_strb <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `ISM_RESP_OKAY;
  end else begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
    if (wr_en) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? `ISM_RESP_SLVERR : `ISM_RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
end

always @(posedge mclk) begin
  if (rst) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= `ISM_RESP_OKAY;
  end else if (rd_en) begin
    s_axi_rvalid <= 1'b1;
    s_axi_rdata <= rd_data;
    s_axi_rresp <= rd_err ? `ISM_RESP_SLVERR : `ISM_RESP_OKAY;
  end else if (s_axi_rready) begin
    s_axi_rvalid <= 1'b0;
  end
end

endmodule

// ### hw/ism_top.v
// Purpose: instrument status monitor register bank
// Assumes: 25 MHz mclk, synchronous active-high rst, AXI4-Lite host
// Notes: health flags arrive from other domains and are synchronised
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`include "ism_defs.vh"

module ism_top #(
  parameter SW = 16,
  parameter CW = 16,
  parameter FIFO_DEPTH = 1024,
  parameter TW = 12,
  parameter WINDOW_CYC = `ISM_CLK_KHZ * `ISM_WINDOW_MS
) (
  input wire mclk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire in1_valid,
  input wire [SW-1:0] in1_sample,
  input wire in2_valid,
  input wire [SW-1:0] in2_sample,
  input wire [1:0] input_overflow,
  input wire analog_pll_fail,
  input wire [1:0] output_dac_ok,
  input wire [1:0] output_clipping,
  input wire [3:0] ext_ref_lock,
  input wire sample_loss,
  input wire [7:0] trigger_state,
  input wire [3:0] pll_lock,
  input wire atomic_ref_lock,
  input wire [3:0] math_unit_overflow,
  input wire [TW-1:0] die_temp_c,
  input wire [CW-1:0] transfer_queue_count,
  input wire queue_write,
  output wire queue_drop,
  input wire tcp_loss_event,
  input wire udp_loss_event,
  output wire irq
);

localparam WCW = 32;
localparam [WCW-1:0] WIN_LAST = WINDOW_CYC - 1;
localparam [TW-1:0] TEMP_LIMIT = `ISM_TEMP_LIMIT_C;
localparam [CW-1:0] QUEUE_FULL = FIFO_DEPTH;
localparam PW = CW + 7;

function hit;
  input [7:0] addr;
  input [7:0] off;
  begin
    hit = (addr[7:2] == off[7:2]);
  end
endfunction

function [31:0] sext;
  input [SW-1:0] v;
  begin
    sext = {{(32-SW){v[SW-1]}}, v};
  end
endfunction

wire wr_en;
wire [7:0] wr_addr;
wire [31:0] wr_data;
wire [3:0] wr_strb;
wire rd_en;
wire [7:0] rd_addr;
reg [31:0] rd_data;
reg rd_err;
reg wr_err;

// Window timing
reg [WCW-1:0] win_cnt;
wire win_end = (win_cnt == WIN_LAST);

always @(posedge mclk) begin
  if (rst)
    win_cnt <= {WCW{1'b0}};
  else if (win_end)
    win_cnt <= {WCW{1'b0}};
  else
    win_cnt <= win_cnt + 1'b1;
end

wire [SW-1:0] in1_high;
wire [SW-1:0] in1_low;
wire [SW-1:0] in2_high;
wire [SW-1:0] in2_low;

ism_peak #(
  .SW(SW)
) u_peak_in1 (
  .mclk(mclk),
  .rst(rst),
  .win_end(win_end),
  .smp_valid(in1_valid),
  .smp(in1_sample),
  .peak_high(in1_high),
  .peak_low(in1_low)
);

ism_peak #(
  .SW(SW)
) u_peak_in2 (
  .mclk(mclk),
  .rst(rst),
  .win_end(win_end),
  .smp_valid(in2_valid),
  .smp(in2_sample),
  .peak_high(in2_high),
  .peak_low(in2_low)
);

// Health flag assembly from asynchronous sources
wire [`ISM_FLG_WIDTH-1:0] flag_raw;
assign flag_raw[`ISM_FLG_IN_OVF+1:`ISM_FLG_IN_OVF] =
  input_overflow;
assign flag_raw[`ISM_FLG_APLL_FAIL] = analog_pll_fail;
assign flag_raw[`ISM_FLG_DAC_OK+1:`ISM_FLG_DAC_OK] =
  output_dac_ok;
assign flag_raw[`ISM_FLG_OUT_CLIP+1:`ISM_FLG_OUT_CLIP] =
  output_clipping;
assign flag_raw[`ISM_FLG_EXT_REF+3:`ISM_FLG_EXT_REF] =
  ext_ref_lock;
assign flag_raw[`ISM_FLG_SAMPLE_LOSS] = sample_loss;
assign flag_raw[`ISM_FLG_PLL_LOCK+3:`ISM_FLG_PLL_LOCK] =
  pll_lock;
assign flag_raw[`ISM_FLG_ATOMIC_LOCK] = atomic_ref_lock;
assign flag_raw[`ISM_FLG_MATH_OVF+3:`ISM_FLG_MATH_OVF] =
  math_unit_overflow;

// Trigger pairs, input n at bits 12+2n and 13+2n
genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_trig
    assign flag_raw[`ISM_FLG_TRIG+2*gi+1:`ISM_FLG_TRIG+2*gi] =
      trigger_state[2*gi+1:2*gi];
  end
endgenerate

reg [`ISM_FLG_WIDTH-1:0] flag_meta;
reg [`ISM_FLG_WIDTH-1:0] flag_sync;
reg [`ISM_FLG_WIDTH-1:0] flag_word;

// Whole word moves together, so a read sees one instant
always @(posedge mclk) begin
  if (rst) begin
    flag_meta <= {`ISM_FLG_WIDTH{1'b0}};
    flag_sync <= {`ISM_FLG_WIDTH{1'b0}};
    flag_word <= {`ISM_FLG_WIDTH{1'b0}};
  end else begin
    flag_meta <= flag_raw;
    flag_sync <= flag_meta;
    flag_word <= flag_sync;
  end
end

// Timestamp, high half frozen when low half is read
reg [63:0] timestamp;
reg [31:0] time_hi_hold;

always @(posedge mclk) begin
  if (rst) begin
    timestamp <= 64'h0000000000000000;
    time_hi_hold <= 32'h00000000;
  end else begin
    timestamp <= timestamp + 64'h0000000000000001;
    if (rd_en && hit(rd_addr, `ISM_OFF_TIME_LO))
      time_hi_hold <= timestamp[63:32];
  end
end

// Over-temperature record
reg over_temp;
wire temp_high = (die_temp_c > TEMP_LIMIT);

always @(posedge mclk) begin
  if (rst)
    over_temp <= 1'b0;
  else if (temp_high)
    over_temp <= 1'b1;
end

// Transfer queue fill percentage
wire [PW-1:0] fill_scaled = transfer_queue_count * 7'd100;
wire [PW-1:0] fill_div = fill_scaled / QUEUE_FULL;
reg [6:0] fill_pct;
wire queue_full = (transfer_queue_count >= QUEUE_FULL);
assign queue_drop = queue_full && queue_write;

always @(posedge mclk) begin
  if (rst)
    fill_pct <= 7'h00;
  else if (queue_full)
    fill_pct <= 7'd`ISM_PERCENT_FULL;
  else
    fill_pct <= fill_div[6:0];
end

// Packet loss records
reg tcp_lost;
reg udp_lost;

always @(posedge mclk) begin
  if (rst) begin
    tcp_lost <= 1'b0;
    udp_lost <= 1'b0;
  end else begin
    if (tcp_loss_event)
      tcp_lost <= 1'b1;
    if (udp_loss_event)
      udp_lost <= 1'b1;
  end
end

// Interrupt status and mask
reg [`ISM_IRQ_WIDTH-1:0] irq_status;
reg [`ISM_IRQ_WIDTH-1:0] irq_mask;
reg temp_high_d;
reg queue_full_d;
wire [`ISM_IRQ_WIDTH-1:0] irq_set;
wire [`ISM_IRQ_WIDTH-1:0] irq_clr;

assign irq_set[`ISM_IRQ_OVER_TEMP] = temp_high && !temp_high_d;
assign irq_set[`ISM_IRQ_TCP_LOSS] = tcp_loss_event;
assign irq_set[`ISM_IRQ_UDP_LOSS] = udp_loss_event;
assign irq_set[`ISM_IRQ_FIFO_FULL] = queue_full && !queue_full_d;
assign irq_clr = (wr_en && wr_strb[0] &&
  hit(wr_addr, `ISM_OFF_IRQ_STATUS)) ?
  wr_data[`ISM_IRQ_WIDTH-1:0] : {`ISM_IRQ_WIDTH{1'b0}};
assign irq = |(irq_status & irq_mask);

// A set in the clearing cycle survives
always @(posedge mclk) begin
  if (rst) begin
    irq_status <= {`ISM_IRQ_WIDTH{1'b0}};
    irq_mask <= `ISM_RST_IRQ_MASK;
    temp_high_d <= 1'b0;
    queue_full_d <= 1'b0;
  end else begin
    temp_high_d <= temp_high;
    queue_full_d <= queue_full;
    irq_status <= (irq_status & ~irq_clr) | irq_set;
    if (wr_en && wr_strb[0] && hit(wr_addr, `ISM_OFF_IRQ_MASK))
      irq_mask <= wr_data[`ISM_IRQ_WIDTH-1:0];
  end
end

// Write decode: status words ignore writes, unmapped gives error
always @* begin
  wr_err = 1'b1;
  if (hit(wr_addr, `ISM_OFF_IRQ_STATUS) ||
      hit(wr_addr, `ISM_OFF_IRQ_MASK))
    wr_err = 1'b0;
  else if (wr_addr < `ISM_OFF_IRQ_STATUS)
    wr_err = 1'b0;
end

// Read decode
always @* begin
  rd_data = 32'h00000000;
  rd_err = 1'b0;
  if (hit(rd_addr, `ISM_OFF_IN1_HIGH))
    rd_data = sext(in1_high);
  else if (hit(rd_addr, `ISM_OFF_IN1_LOW))
    rd_data = sext(in1_low);
  else if (hit(rd_addr, `ISM_OFF_IN2_HIGH))
    rd_data = sext(in2_high);
  else if (hit(rd_addr, `ISM_OFF_IN2_LOW))
    rd_data = sext(in2_low);
  else if (hit(rd_addr, `ISM_OFF_TIME_LO))
    rd_data = timestamp[31:0];
  else if (hit(rd_addr, `ISM_OFF_TIME_HI))
    rd_data = time_hi_hold;
  else if (hit(rd_addr, `ISM_OFF_FLAGS))
    rd_data = {{(32-`ISM_FLG_WIDTH){1'b0}}, flag_word};
  else if (hit(rd_addr, `ISM_OFF_TCP_LOSS))
    rd_data = {31'h00000000, tcp_lost};
  else if (hit(rd_addr, `ISM_OFF_UDP_LOSS))
    rd_data = {31'h00000000, udp_lost};
  else if (hit(rd_addr, `ISM_OFF_FIFO_FILL))
    rd_data = {25'h0000000, fill_pct};
  else if (hit(rd_addr, `ISM_OFF_OVER_TEMP))
    rd_data = {31'h00000000, over_temp};
  else if (hit(rd_addr, `ISM_OFF_IRQ_STATUS))
    rd_data = {{(32-`ISM_IRQ_WIDTH){1'b0}}, irq_status};
  else if (hit(rd_addr, `ISM_OFF_IRQ_MASK))
    rd_data = {{(32-`ISM_IRQ_WIDTH){1'b0}}, irq_mask};
  else
    rd_err = 1'b1;
end

ism_axil u_bus (
  .mclk(mclk),
  .rst(rst),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .wr_en(wr_en),
  .wr_addr(wr_addr),
  .wr_data(wr_data),
  .wr_strb(wr_strb),
  .wr_err(wr_err),
  .rd_en(rd_en),
  .rd_addr(rd_addr),
  .rd_data(rd_data),
  .rd_err(rd_err)
);

endmodule

// ### test/ism_top_properties.sv
// Purpose: bus, queue and reset properties of the status monitor
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the top module below
module ism_top_chk #(
  parameter CW = 16,
  parameter FIFO_DEPTH = 1024
) (
  input wire mclk,
  input wire rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [CW-1:0] transfer_queue_count,
  input wire queue_write,
  input wire queue_drop,
  input wire irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  read_ans_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  read_done_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  write_ans_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  write_done_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  unmapped_err_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h33
    |=> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  drop_full_a: assert property (
    queue_drop == (queue_write && transfer_queue_count >= FIFO_DEPTH))
    else $error("drop does not follow full queue");
  reset_clear_a: assert property (
    $fell(rst) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state not cleared by reset");
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  cover property (irq);
  cover property (queue_drop);
endmodule

bind ism_top ism_top_chk #(.CW(CW), .FIFO_DEPTH(FIFO_DEPTH)) i_ism_top_chk (
  .mclk(mclk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .transfer_queue_count(transfer_queue_count),
  .queue_write(queue_write), .queue_drop(queue_drop), .irq(irq));

// ### test/tb_top.sv
// Purpose: self-checking bench for the status monitor
// Assumes: AXI4-Lite master tasks, 20-cycle peak window
// Notes: samples run freely so every window sees the whole pattern
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, v1 = 0, qw = 0, tcp = 0, udp = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdat, rdata, tlo;
  logic [1:0] bresp, rresp, rrsp, ph = 0;
  logic awready, wready, bvalid, arready, rvalid, drop, irq;
  logic [15:0] s1 = 0, cnt = 0;
  logic [15:0] pk [4] = '{16'h0064, 16'hff38, 16'h0032, 16'h0000};
  logic [28:0] fl = 0;
  logic [11:0] temp = 0;
  int err_total = 0, n_checks = 0;
  ism_top #(.WINDOW_CYC(20)) i_ism_top (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .in1_valid(v1), .in1_sample(s1), .in2_valid(v1), .in2_sample(~s1),
    .input_overflow(fl[1:0]), .analog_pll_fail(fl[2]),
    .output_dac_ok(fl[4:3]), .output_clipping(fl[6:5]),
    .ext_ref_lock(fl[10:7]), .sample_loss(fl[11]),
    .trigger_state(fl[19:12]), .pll_lock(fl[23:20]),
    .atomic_ref_lock(fl[24]), .math_unit_overflow(fl[28:25]),
    .die_temp_c(temp), .transfer_queue_count(cnt), .queue_write(qw),
    .queue_drop(drop), .tcp_loss_event(tcp), .udp_loss_event(udp),
    .irq(irq));
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    ph <= ph + 2'd1;
    s1 <= pk[ph];
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      k++;
    end while (!bvalid && k < 50);
    bready <= 0;
    if (!bvalid) err_total++;
    chk("bresp", 32'h0, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a);
    int k = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 0;
      k++;
    end while (!rvalid && k < 50);
    rready <= 0;
    if (!rvalid) err_total++;
    rdat = rdata;
    rrsp = rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("rresp", 32'h0, {30'h0, rrsp});
    chk("rdata", e, rdat);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 0;
    v1 <= 1;
    rc(8'h30, 32'h0);
    rd(8'h40);
    chk("unmapped", 32'h2, {30'h0, rrsp});
    for (int i = 0; i < 2; i++) begin
      fl <= i ? 29'h0dcb_a987 : 29'h1234_5678;
      repeat (4) @(posedge mclk);
      rc(8'h18, {3'h0, fl});
    end
    repeat (45) @(posedge mclk);
    rc(8'h00, 32'h0000_0064);
    rc(8'h04, 32'hffff_ff38);
    rc(8'h08, 32'h0000_00c7);
    rc(8'h0c, 32'hffff_ff9b);
    rd(8'h10);
    tlo = rdat;
    rd(8'h10);
    chk("time_step", 32'h1, {31'h0, rdat > tlo});
    rc(8'h14, 32'h0);
    cnt <= 16'd1023;
    qw <= 1;
    repeat (2) @(posedge mclk);
    chk("drop", 32'h0, {31'h0, drop});
    rc(8'h24, 32'd99);
    cnt <= 16'd1024;
    repeat (2) @(posedge mclk);
    chk("drop", 32'h1, {31'h0, drop});
    rc(8'h24, 32'd100);
    cnt <= 16'd512;
    qw <= 0;
    repeat (2) @(posedge mclk);
    rc(8'h24, 32'd50);
    tcp <= 1;
    udp <= 1;
    @(posedge mclk);
    tcp <= 0;
    udp <= 0;
    rc(8'h1c, 32'h1);
    rc(8'h20, 32'h1);
    wr(8'h1c, 32'h0);
    rc(8'h1c, 32'h1);
    temp <= 12'd85;
    repeat (3) @(posedge mclk);
    rc(8'h28, 32'h0);
    temp <= 12'd86;
    repeat (3) @(posedge mclk);
    rc(8'h28, 32'h1);
    rc(8'h2c, 32'hf);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h30, 32'h1);
    @(posedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    temp <= 12'd20;
    wr(8'h2c, 32'hf);
    @(posedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    rc(8'h2c, 32'h0);
    rc(8'h28, 32'h1);
    rst <= 1;
    repeat (2) @(posedge mclk);
    rst <= 0;
    rc(8'h28, 32'h0);
    rc(8'h1c, 32'h0);
    end_sim;
  end
endmodule
